// file: core/icrw_channel.sv
`timescale 1ns/100ps
`include "icrw_map.svh"

// one isolated channel: encoder on the input side, latch and
// watchdog on the output side
module icrw_channel #(
  parameter int REFRESH_CYC  = `ICRW_REFRESH_CYC,
  parameter int WATCHDOG_CYC = `ICRW_WATCHDOG_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic tx_active,
  input  wire logic rx_active,
  input  wire logic din,
  output logic      dout
);

  // ---------------------------------------------------------------
  // input-side encoder
  // ---------------------------------------------------------------
  logic                     din_q, din_d;
  logic [`ICRW_CNT_W-1:0]   idle_q, idle_d;
  icrw_pkg::icrw_pulse_t    pls_q, pls_d;

  // level to set or reset request, shared by edges and refreshes
  function automatic icrw_pkg::icrw_pulse_t pulse_of(input logic lvl);
    icrw_pkg::icrw_pulse_t p;
    p.set = lvl;
    p.rst = !lvl;
    return p;
  endfunction : pulse_of

  // edges make a one-cycle pulse, idle input is refreshed
  always_comb begin
    din_d  = din;
    idle_d = idle_q;
    pls_d  = '0;
    if (!tx_active) begin
      din_d  = `ICRW_OUT_RST;
      idle_d = '0;
    end else if (din != din_q) begin
      pls_d     = pulse_of(din);
      idle_d    = '0;
    end else if (idle_q >= `ICRW_CNT_W'(REFRESH_CYC - 1)) begin
      pls_d     = pulse_of(din);
      idle_d    = '0;
    end else begin
      idle_d = idle_q + `ICRW_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      din_q  <= `ICRW_OUT_RST;
      idle_q <= '0;
      pls_q  <= '0;
    end else begin
      din_q  <= din_d;
      idle_q <= idle_d;
      pls_q  <= pls_d;
    end
  end

  // ---------------------------------------------------------------
  // output-side bistable decoder with watchdog
  // ---------------------------------------------------------------
  logic                     lat_q, lat_d;
  logic [`ICRW_CNT_W-1:0]   wd_q, wd_d;

  // pulses arriving while the receiver is locked are dropped
  always_comb begin
    lat_d = lat_q;
    wd_d  = wd_q;
    if (!rx_active) begin
      lat_d = `ICRW_OUT_RST;
      wd_d  = '0;
    end else if (pls_q.set || pls_q.rst) begin
      lat_d = pls_q.set;
      wd_d  = '0;
    end else if (wd_q >= `ICRW_CNT_W'(WATCHDOG_CYC - 1)) begin
      lat_d = `ICRW_OUT_RST;
    end else begin
      wd_d = wd_q + `ICRW_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lat_q <= `ICRW_OUT_RST;
      wd_q  <= '0;
    end else begin
      lat_q <= lat_d;
      wd_q  <= wd_d;
    end
  end

  assign dout = lat_q;

endmodule : icrw_channel

// file: core/icrw_map.svh
`ifndef ICRW_MAP_SVH
`define ICRW_MAP_SVH

// ---------------------------------------------------------------
// timing figures and derived counts (core_clk at 50 MHz)
// ---------------------------------------------------------------
`define ICRW_CLK_MHZ          50
`define ICRW_PULSE_NS         1
`define ICRW_REFRESH_US       1
`define ICRW_WATCHDOG_US      5
`define ICRW_SETTLE_US        1
// a 1 ns pulse is far below one 20 ns cycle, so it becomes one cycle
`define ICRW_PULSE_CYC        1
// idle time before a refresh: least time, rounded up
`define ICRW_REFRESH_CYC      (`ICRW_REFRESH_US * `ICRW_CLK_MHZ)
// watchdog time: longest time, rounded down
`define ICRW_WATCHDOG_CYC     (`ICRW_WATCHDOG_US * `ICRW_CLK_MHZ)
`define ICRW_SETTLE_CYC       (`ICRW_SETTLE_US * `ICRW_CLK_MHZ)
`define ICRW_CNT_W            16
// reset value of every channel encoder and decoder
`define ICRW_OUT_RST          1'h0

`endif

// file: core/icrw_pkg.sv
package icrw_pkg;

  // one coupled pulse: set or reset request for a decoder
  typedef struct packed {
    logic set;
    logic rst;
  } icrw_pulse_t;

  // side power states
  typedef enum logic [1:0] {
    ICRW_LOCKED,
    ICRW_ACTIVE
  } icrw_side_t;

endpackage : icrw_pkg

// file: core/icrw_top.sv
`timescale 1ns/100ps
`include "icrw_map.svh"

// ---------------------------------------------------------------
// ---------------------------------------------------------------
module icrw_top #(
  parameter int FWD_CH       = 2,
  parameter int REV_CH       = 2,
  parameter int REFRESH_CYC  = `ICRW_REFRESH_CYC,
  parameter int WATCHDOG_CYC = `ICRW_WATCHDOG_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              primary_supply_ok,
  input  wire logic              isolated_secondary_supply_ok,
  input  wire logic              sec_in_regulation,
  input  wire logic              sec_pwm,
  input  wire logic [FWD_CH-1:0] pri_din,
  input  wire logic [REV_CH-1:0] sec_din,
  output logic      [FWD_CH-1:0] sec_dout,
  output logic      [FWD_CH-1:0] sec_dout_oe_n,
  output logic      [REV_CH-1:0] pri_dout,
  output logic      [REV_CH-1:0] pri_dout_oe_n,
  output logic                   osc_en,
  output logic                   pri_lockout,
  output logic                   sec_lockout
);

  // ---------------------------------------------------------------
  // supply lockout state of each side
  // ---------------------------------------------------------------
  icrw_pkg::icrw_side_t pri_st_q, pri_st_d;
  icrw_pkg::icrw_side_t sec_st_q, sec_st_d;
  logic                 pri_lo_q, pri_lo_d;
  logic                 sec_lo_q, sec_lo_d;
  logic                 pri_act, sec_act;

  // supply level to side state, one rule for both sides
  function automatic icrw_pkg::icrw_side_t side_next(input logic supply_ok);
    icrw_pkg::icrw_side_t st;
    st = icrw_pkg::ICRW_LOCKED;
    if (supply_ok) begin
      st = icrw_pkg::ICRW_ACTIVE;
    end
    return st;
  endfunction : side_next

  // side state to activity flag
  function automatic logic side_up(input icrw_pkg::icrw_side_t st);
    return st == icrw_pkg::ICRW_ACTIVE;
  endfunction : side_up

  // the secondary follows its own supply input only; a separate
  // lockout register keeps those pins straight from a flip-flop
  always_comb begin
    pri_st_d = side_next(primary_supply_ok);
    sec_st_d = side_next(isolated_secondary_supply_ok);
    pri_lo_d = !side_up(pri_st_d);
    sec_lo_d = !side_up(sec_st_d);
  end

  // state and lockout registers, both sides start locked
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pri_st_q <= icrw_pkg::ICRW_LOCKED;
      sec_st_q <= icrw_pkg::ICRW_LOCKED;
      pri_lo_q <= 1'h1;
      sec_lo_q <= 1'h1;
    end else begin
      pri_st_q <= pri_st_d;
      sec_st_q <= sec_st_d;
      pri_lo_q <= pri_lo_d;
      sec_lo_q <= sec_lo_d;
    end
  end

  // activity seen by channels and pins
  assign pri_act = side_up(pri_st_q);
  assign sec_act = side_up(sec_st_q);

  // ---------------------------------------------------------------
  // channels: forward primary to secondary, reverse the other way
  // ---------------------------------------------------------------
  logic [FWD_CH-1:0] fwd_out;
  logic [REV_CH-1:0] rev_out;

  // forward: primary encodes, secondary decodes
  for (genvar i = 0; i < FWD_CH; i++) begin : g_fwd
    icrw_channel #(
      .REFRESH_CYC  (REFRESH_CYC),
      .WATCHDOG_CYC (WATCHDOG_CYC)
    ) u_ch (
      .core_clk  (core_clk),
      .rst       (rst),
      .tx_active (pri_act),
      .rx_active (sec_act),
      .din       (pri_din[i]),
      .dout      (fwd_out[i])
    );
  end

  // reverse: secondary encodes, primary decodes
  for (genvar j = 0; j < REV_CH; j++) begin : g_rev
    icrw_channel #(
      .REFRESH_CYC  (REFRESH_CYC),
      .WATCHDOG_CYC (WATCHDOG_CYC)
    ) u_ch (
      .core_clk  (core_clk),
      .rst       (rst),
      .tx_active (sec_act),
      .rx_active (pri_act),
      .din       (sec_din[j]),
      .dout      (rev_out[j])
    );
  end

  // ---------------------------------------------------------------
  // secondary pins
  // ---------------------------------------------------------------
  logic [FWD_CH-1:0] sec_dout_q, sec_dout_d;
  logic [FWD_CH-1:0] sec_oe_n_q, sec_oe_n_d;

  // a locked side floats and reads low, enable low means driven;
  // gating here too so no stale latch value leaks at power-up
  always_comb begin
    sec_dout_d = '0;
    sec_oe_n_d = '1;
    if (sec_act) begin
      sec_dout_d = fwd_out;
      sec_oe_n_d = '0;
    end
  end

  // secondary pin registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sec_dout_q <= '0;
      sec_oe_n_q <= '1;
    end else begin
      sec_dout_q <= sec_dout_d;
      sec_oe_n_q <= sec_oe_n_d;
    end
  end

  // ---------------------------------------------------------------
  // primary pins
  // ---------------------------------------------------------------
  logic [REV_CH-1:0] pri_dout_q, pri_dout_d;
  logic [REV_CH-1:0] pri_oe_n_q, pri_oe_n_d;

  // same gating; low until the secondary sends data
  always_comb begin
    pri_dout_d = '0;
    pri_oe_n_d = '1;
    if (pri_act) begin
      pri_dout_d = rev_out;
      pri_oe_n_d = '0;
    end
  end

  // primary pin registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pri_dout_q <= '0;
      pri_oe_n_q <= '1;
    end else begin
      pri_dout_q <= pri_dout_d;
      pri_oe_n_q <= pri_oe_n_d;
    end
  end

  // ---------------------------------------------------------------
  // power oscillator control
  // ---------------------------------------------------------------
  logic osc_q, osc_d;

  // free run until regulation, then follow the pwm gate; the gate
  // lands one cycle late, the price of a registered pin
  always_comb begin
    if (!pri_act) begin
      osc_d = 1'h0;
    end else if (!sec_act || !sec_in_regulation) begin
      osc_d = 1'h1;
    end else begin
      osc_d = sec_pwm;
    end
  end

  // oscillator enable register, off through reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_q <= 1'h0;
    end else begin
      osc_q <= osc_d;
    end
  end

  // ---------------------------------------------------------------
  // output pins, each straight from its register
  // ---------------------------------------------------------------
  assign sec_dout      = sec_dout_q;
  assign pri_dout      = pri_dout_q;
  assign sec_dout_oe_n = sec_oe_n_q;
  assign pri_dout_oe_n = pri_oe_n_q;
  assign osc_en        = osc_q;
  assign pri_lockout   = pri_lo_q;
  assign sec_lockout   = sec_lo_q;

endmodule : icrw_top

// file: sim/icrw_far_side.sv
`timescale 1ns/100ps
// secondary supply charged by the oscillator, with its pwm loop
module icrw_far_side (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic osc_en,
  output logic      sup_ok,
  output logic      in_reg,
  output logic      pwm
);
  logic [5:0] chg_q, chg_d;
  logic [1:0] ph_q, ph_d;
  // slow decay, so the watchdog acts before the supply drops out
  always_comb begin
    chg_d = chg_q;
    if (osc_en && !(&chg_q)) begin
      chg_d = chg_q + 6'h01;
    end else if (!osc_en && |chg_q && ph_q[0]) begin
      chg_d = chg_q - 6'h01;
    end
    ph_d = ph_q + 2'h1;
  end
  // state registers
  always_ff @(posedge core_clk) begin
    chg_q <= rst ? 6'h00 : chg_d;
    ph_q  <= rst ? 2'h0 : ph_d;
  end
  // pwm only once regulated, high three cycles in four
  assign sup_ok = chg_q >= 6'h04;
  assign in_reg = chg_q >= 6'h10;
  assign pwm    = in_reg && ph_q != 2'h0;
endmodule : icrw_far_side

// file: sim/icrw_top_assertions.sv
`timescale 1ns/100ps
// port checks, all on core_clk
module icrw_top_assertions #(
  parameter int FWD_CH       = 2,
  parameter int REFRESH_CYC  = 8,
  parameter int WATCHDOG_CYC = 30
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              sec_in_regulation,
  input wire logic              sec_pwm,
  input wire logic [FWD_CH-1:0] pri_din,
  input wire logic [FWD_CH-1:0] sec_dout,
  input wire logic [FWD_CH-1:0] sec_dout_oe_n,
  input wire logic              osc_en,
  input wire logic              pri_lockout,
  input wire logic              sec_lockout
);
  logic              act;
  logic [7:0]        off_q, off_d, st_q, st_d;
  logic [FWD_CH-1:0] din_q;
  assign act = !pri_lockout && !sec_lockout;
  // saturating counts, so a long idle stretch never wraps
  always_comb begin
    off_d = !pri_lockout ? 8'h00 : (&off_q ? off_q : off_q + 8'h01);
    st_d  = (!act || pri_din != din_q) ? 8'h00 : (&st_q ? st_q : st_q + 8'h01);
  end
  // helper registers
  always_ff @(posedge core_clk) begin
    off_q <= rst ? 8'h00 : off_d;
    st_q  <= rst ? 8'h00 : st_d;
    din_q <= pri_din;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_osc_locked: assert property (
    pri_lockout && $past(pri_lockout) |-> !osc_en) else $error("osc on in lockout");
  a_free_run: assert property (
    !pri_lockout && !$past(pri_lockout) && !sec_in_regulation && !$past(sec_in_regulation)
    |-> osc_en) else $error("osc not free running");
  a_pwm_gate: assert property (
    act && $past(act) && sec_in_regulation && $past(sec_in_regulation)
    |-> osc_en == $past(sec_pwm)) else $error("osc not gated by pwm");
  a_sec_hiz: assert property (
    sec_dout_oe_n == {FWD_CH{$past(sec_lockout)}}) else $error("enable off lockout");
  a_sec_init: assert property (
    $fell(sec_lockout) |-> sec_dout == '0) else $error("output not low at start");
  a_watchdog_low: assert property (
    off_q > WATCHDOG_CYC + 6 && !sec_lockout |-> sec_dout == '0) else $error("no watchdog");
  a_refresh_holds: assert property (
    st_q > REFRESH_CYC + 6 |-> sec_dout == pri_din) else $error("output stale");
  a_edge_latency: assert property (
    $changed(pri_din) && act ##1 act ##1 act |-> ##1 sec_dout == $past(pri_din, 3))
    else $error("edge not passed in three cycles");
  c_edge: cover property (act && $changed(pri_din));
  c_gated: cover property (act && sec_in_regulation && !osc_en);
  c_dog: cover property (pri_lockout && !sec_lockout && $fell(sec_dout[0]));
endmodule : icrw_top_assertions

// file: sim/icrw_top_test.sv
`timescale 1ns/100ps
// short refresh and watchdog keep the run brief
module icrw_top_test;
  localparam int RC = 8;
  localparam int WC = 30;
  logic       core_clk, rst, pri_ok, iso_ok, in_reg, pwm, osc_en, pri_lo, sec_lo, p;
  logic [1:0] pri_din, sec_din, sec_dout, sec_oe_n, pri_dout, pri_oe_n, v;
  int         n_fail, checked;
  icrw_top #(.REFRESH_CYC(RC), .WATCHDOG_CYC(WC)) dut (
    .core_clk(core_clk), .rst(rst), .primary_supply_ok(pri_ok),
    .isolated_secondary_supply_ok(iso_ok), .sec_in_regulation(in_reg), .sec_pwm(pwm),
    .pri_din(pri_din), .sec_din(sec_din), .sec_dout(sec_dout), .sec_dout_oe_n(sec_oe_n),
    .pri_dout(pri_dout), .pri_dout_oe_n(pri_oe_n), .osc_en(osc_en), .pri_lockout(pri_lo),
    .sec_lockout(sec_lo));
  icrw_far_side far (.core_clk(core_clk), .rst(rst), .osc_en(osc_en), .sup_ok(iso_ok),
    .in_reg(in_reg), .pwm(pwm));
  // clock
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic wait_for(ref logic s, input logic lvl);
    for (int k = 0; k < 300 && s !== lvl; k++) cyc(1);
    if (s !== lvl) begin
      n_fail++;
      results();
    end
  endtask : wait_for
  task automatic t_up();
    pri_din = 2'h2;
    sec_din = 2'h1;
    pri_ok  = 1'h1;
    cyc(3);
    chk({pri_lo, osc_en, pri_oe_n, pri_dout}, 8'h10);
    chk(sec_oe_n, 8'h03);
    wait_for(sec_lo, 1'h0);
    cyc(RC + 6);
    chk({sec_oe_n, sec_dout, pri_dout}, 8'h09);
  endtask : t_up
  task automatic t_edges();
    logic [1:0] tbl [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    v = 2'h2;
    foreach (tbl[k]) begin
      pri_din = tbl[k];
      sec_din = ~tbl[k];
      cyc(2);
      chk(sec_dout, v);
      cyc(1);
      chk({sec_dout, pri_dout}, {tbl[k], ~tbl[k]});
      v = tbl[k];
    end
    pri_din = 2'h3;
    cyc(WC + 10);
    chk(sec_dout, 8'h03);
  endtask : t_edges
  task automatic t_reg();
    wait_for(in_reg, 1'h1);
    cyc(2);
    repeat (8) begin
      p = pwm;
      cyc(1);
      chk(osc_en, p);
    end
  endtask : t_reg
  task automatic t_down();
    pri_ok = 1'h0;
    cyc(3);
    chk({pri_lo, osc_en, pri_oe_n}, 8'h0B);
    cyc(10);
    chk(sec_dout, 8'h03);
    cyc(WC);
    chk({sec_lo, sec_dout}, 8'h00);
    wait_for(sec_lo, 1'h1);
    cyc(2);
    chk(sec_oe_n, 8'h03);
  endtask : t_down
  // reset held 16 cycles, then both sides must sit in lockout
  task automatic t_reset();
    rst     = 1'h1;
    pri_ok  = 1'h0;
    pri_din = 2'h0;
    sec_din = 2'h0;
    cyc(16);
    rst = 1'h0;
    chk({osc_en, pri_lo, sec_lo, sec_oe_n, pri_oe_n}, 8'h3F);
    chk({sec_dout, pri_dout}, 8'h00);
  endtask : t_reset
  // main sequence
  initial begin
    n_fail  = 0;
    checked = 0;
    t_reset();
    t_up();
    t_edges();
    t_reg();
    t_down();
    results();
  end
endmodule : icrw_top_test
bind icrw_top icrw_top_assertions #(.FWD_CH(FWD_CH), .REFRESH_CYC(REFRESH_CYC),
  .WATCHDOG_CYC(WATCHDOG_CYC)) u_chk (.core_clk(core_clk), .rst(rst),
  .sec_in_regulation(sec_in_regulation), .sec_pwm(sec_pwm), .pri_din(pri_din),
  .sec_dout(sec_dout), .sec_dout_oe_n(sec_dout_oe_n), .osc_en(osc_en),
  .pri_lockout(pri_lockout), .sec_lockout(sec_lockout));
